//--- egp_pkg.sv
package egp_pkg;

    // ****************************************
    // register byte addresses
    // ****************************************
    localparam logic [7:0] ADDR_MON_LO    = 8'h10;
    localparam logic [7:0] ADDR_MON_HI    = 8'h11;
    localparam logic [7:0] ADDR_OUT_LO    = 8'h12;
    localparam logic [7:0] ADDR_OUT_HI    = 8'h13;
    localparam logic [7:0] ADDR_DIR_LO    = 8'h14;
    localparam logic [7:0] ADDR_DIR_HI    = 8'h15;
    localparam logic [7:0] ADDR_POL_LO    = 8'h16;
    localparam logic [7:0] ADDR_POL_HI    = 8'h17;
    localparam logic [7:0] ADDR_RSV_FIRST = 8'h18;
    localparam logic [7:0] ADDR_TOP       = 8'hff;
    localparam logic [7:0] ADDR_WRAP      = 8'h00;

    // ****************************************
    // reset values and widths
    // ****************************************
    localparam int          PIN_COUNT    = 16;
    localparam logic [15:0] RST_OUT      = 16'h0000;
    localparam logic [15:0] RST_DIR      = 16'h0000;
    localparam logic [15:0] RST_POL      = 16'h0000;
    localparam logic [7:0]  RST_PTR      = 8'h00;
    localparam logic [7:0]  RST_RDATA    = 8'h00;
    localparam logic [7:0]  RSV_RDATA    = 8'h00;

endpackage

//--- egp_sync2.sv
module egp_sync2 #(
    parameter int WIDTH = 16
) (
    input  wire logic             clk_sys,
    input  wire logic             rst_n,
    input  wire logic             ce,
    input  wire logic [WIDTH-1:0] din,
    output logic      [WIDTH-1:0] dout
);

    logic [WIDTH-1:0] meta_ff;

    // first stage feeds only the second stage
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta_ff <= '0;
            dout    <= '0;
        end
        else if (ce)
        begin
            meta_ff <= din;
            dout    <= meta_ff;
        end
    end

endmodule

//--- egp_port.sv
// Summary of operation
// RULE1 - sixteen pins, each set individually as input or output
// RULE2 - pointer auto-increments per access; 0x18-0xff reserved; wraps 0xff to 0x00
// RULE3 - each register spans two addresses: low byte pins 7-0, high 15-8
// RULE4 - monitor register reads live pin levels; writes to it are ignored
// RULE5 - output register one drives pin high, zero drives it low
// RULE6 - direction bit zero means input, one means output
// RULE7 - direction register clears on reset, all pins inputs
// RULE8 - polarity bit one inverts reported input, zero reports unchanged
// RULE9 - polarity register resets to zero
// RULE10 - bit x of every register belongs to pin x
// RULE11 - inversion applies to the value the host reads back
// RULE12 - power-on reset holds everything in reset until supply valid
// RULE13 - during reset every pin is an input
// RULE14 - host should set unused pins as outputs to save power
// RULE15 - output value drives a pin only while its direction is output
// RULE16 - writable registers read back last write, each byte independently
module egp_port #(
    parameter int NPINS = egp_pkg::PIN_COUNT
) (
    input  wire logic             clk_sys,
    input  wire logic             rst_n,
    input  wire logic             ce,
    input  wire logic             ptr_load,
    input  wire logic [7:0]       ptr_addr,
    input  wire logic             wr_en,
    input  wire logic [7:0]       wr_data,
    input  wire logic             rd_en,
    output logic      [7:0]       rd_data,
    output logic                  rd_valid,
    output logic      [7:0]       ptr,
    input  wire logic [NPINS-1:0] pin_in,
    output logic      [NPINS-1:0] pin_out,
    output logic      [NPINS-1:0] pin_oe
);

    // ****************************************
    // state
    // ****************************************
    logic [NPINS-1:0] out_ff;
    logic [NPINS-1:0] dir_ff;
    logic [NPINS-1:0] pol_ff;
    logic [7:0]       ptr_ff;
    logic [7:0]       rdata_ff;
    logic             rvalid_ff;
    logic [NPINS-1:0] pin_out_ff;
    logic [NPINS-1:0] pin_oe_ff;
    logic [NPINS-1:0] pin_sync;
    logic [NPINS-1:0] monitor;
    logic [7:0]       acc_addr;
    logic [7:0]       nxt_rdata;
    logic             wr_out_lo;
    logic             wr_out_hi;
    logic             wr_dir_lo;
    logic             wr_dir_hi;
    logic             wr_pol_lo;
    logic             wr_pol_hi;

    // pins come from outside the clock domain
    egp_sync2 #(
        .WIDTH (NPINS)
    ) u_sync (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .ce      (ce),
        .din     (pin_in),
        .dout    (pin_sync)
    );

    // ****************************************
    // access address and pointer
    // ****************************************
    // a load in the same cycle as an access addresses the loaded location
    assign acc_addr = ptr_load ? ptr_addr : ptr_ff;

    // 8-bit pointer rolls 0xff to 0x00 naturally
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            ptr_ff <= egp_pkg::RST_PTR;
        else if (ce)
        begin
            if (wr_en || rd_en)
                ptr_ff <= 8'(acc_addr + 8'h01); // RULE2
            else if (ptr_load)
                ptr_ff <= ptr_addr;
        end
    end

    // ****************************************
    // write decode
    // ****************************************
    // one strobe per writable byte, gated by ce so a frozen block ignores writes
    always_comb
    begin
        wr_out_lo = 1'b0;
        wr_out_hi = 1'b0;
        wr_dir_lo = 1'b0;
        wr_dir_hi = 1'b0;
        wr_pol_lo = 1'b0;
        wr_pol_hi = 1'b0;
        if (ce && wr_en)
        begin
            // monitor and reserved addresses decode to no strobe
            unique case (acc_addr)
                egp_pkg::ADDR_OUT_LO: wr_out_lo = 1'b1; // RULE3
                egp_pkg::ADDR_OUT_HI: wr_out_hi = 1'b1; // RULE3
                egp_pkg::ADDR_DIR_LO: wr_dir_lo = 1'b1;
                egp_pkg::ADDR_DIR_HI: wr_dir_hi = 1'b1;
                egp_pkg::ADDR_POL_LO: wr_pol_lo = 1'b1;
                egp_pkg::ADDR_POL_HI: wr_pol_hi = 1'b1;
                default: ; // RULE4
            endcase
        end
    end

    // ****************************************
    // writable registers
    // ****************************************
    // asynchronous reset stands for the power-on reset
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            out_ff <= egp_pkg::RST_OUT;
        else
        begin
            if (wr_out_lo)
                out_ff[7:0] <= wr_data; // RULE3 RULE16
            if (wr_out_hi)
                out_ff[15:8] <= wr_data; // RULE3 RULE16
        end
    end

    // reset leaves every pin an input until the host says otherwise
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            dir_ff <= egp_pkg::RST_DIR; // RULE7 RULE12
        else
        begin
            if (wr_dir_lo)
                dir_ff[7:0] <= wr_data; // RULE16
            if (wr_dir_hi)
                dir_ff[15:8] <= wr_data; // RULE16
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            pol_ff <= egp_pkg::RST_POL; // RULE9
        else
        begin
            if (wr_pol_lo)
                pol_ff[7:0] <= wr_data; // RULE16
            if (wr_pol_hi)
                pol_ff[15:8] <= wr_data; // RULE16
        end
    end

    // ****************************************
    // read path
    // ****************************************
    assign monitor = pin_sync ^ pol_ff; // RULE8 RULE11 RULE10

    always_comb
    begin
        nxt_rdata = egp_pkg::RSV_RDATA;
        unique case (acc_addr)
            egp_pkg::ADDR_MON_LO: nxt_rdata = monitor[7:0];  // RULE4 RULE3
            egp_pkg::ADDR_MON_HI: nxt_rdata = monitor[15:8]; // RULE4 RULE3
            egp_pkg::ADDR_OUT_LO: nxt_rdata = out_ff[7:0];   // RULE16
            egp_pkg::ADDR_OUT_HI: nxt_rdata = out_ff[15:8];
            egp_pkg::ADDR_DIR_LO: nxt_rdata = dir_ff[7:0];
            egp_pkg::ADDR_DIR_HI: nxt_rdata = dir_ff[15:8];
            egp_pkg::ADDR_POL_LO: nxt_rdata = pol_ff[7:0];
            egp_pkg::ADDR_POL_HI: nxt_rdata = pol_ff[15:8];
            default:              nxt_rdata = egp_pkg::RSV_RDATA;
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rdata_ff  <= egp_pkg::RST_RDATA;
            rvalid_ff <= 1'b0;
        end
        else if (ce)
        begin
            rvalid_ff <= rd_en;
            if (rd_en)
                rdata_ff <= nxt_rdata;
        end
    end

    // ****************************************
    // pin drive
    // ****************************************
    // registered so pads never see decode glitches
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pin_out_ff <= '0;
            pin_oe_ff  <= '0; // RULE13
        end
        else if (ce)
        begin
            pin_out_ff <= out_ff & dir_ff; // RULE5 RULE15
            pin_oe_ff  <= dir_ff;          // RULE1 RULE6 RULE10
        end
    end

    assign pin_out  = pin_out_ff;
    assign pin_oe   = pin_oe_ff;
    assign rd_data  = rdata_ff;
    assign rd_valid = rvalid_ff;
    assign ptr      = ptr_ff;

endmodule

//--- egp_port_assertions.sv
module egp_port_assertions (
    input wire logic        clk_sys,
    input wire logic        rst_n,
    input wire logic        ce,
    input wire logic        ptr_load,
    input wire logic [7:0]  ptr_addr,
    input wire logic        wr_en,
    input wire logic [7:0]  wr_data,
    input wire logic        rd_en,
    input wire logic [7:0]  rd_data,
    input wire logic        rd_valid,
    input wire logic [7:0]  ptr,
    input wire logic [15:0] pin_out,
    input wire logic [15:0] pin_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    a_read_valid: assert property (ce && rd_en |=> rd_valid)
        else $error("rd_valid missing");
    a_idle_valid: assert property (ce && !rd_en |=> !rd_valid)
        else $error("stray rd_valid");
    a_oe_gate: assert property ((pin_out & ~pin_oe) == 16'h0000)
        else $error("input pin driven");
    a_ptr_step: assert property (ce && !ptr_load && (rd_en || wr_en)
        |=> ptr == $past(ptr) + 8'h01) else $error("ptr step");
    a_ptr_load: assert property (ce && ptr_load && wr_en
        |=> ptr == $past(ptr_addr) + 8'h01) else $error("ptr load");
    a_rst_input: assert property ($rose(rst_n) |-> pin_oe == 16'h0000)
        else $error("pin driven after reset");
    a_dir_low: assert property (ce && wr_en && !ptr_load && ptr == 8'h14
        |-> ##2 pin_oe[7:0] == $past(wr_data, 2)) else $error("dir write");
    a_rsv_read: assert property (ce && rd_en && !ptr_load && ptr >= 8'h18
        |=> rd_data == 8'h00) else $error("reserved read");
endmodule

bind egp_port egp_port_assertions i_chk (.clk_sys(clk_sys), .rst_n(rst_n), .ce(ce),
    .ptr_load(ptr_load), .ptr_addr(ptr_addr), .wr_en(wr_en), .wr_data(wr_data),
    .rd_en(rd_en), .rd_data(rd_data), .rd_valid(rd_valid), .ptr(ptr),
    .pin_out(pin_out), .pin_oe(pin_oe));

//--- egp_pin_env.sv
module egp_pin_env (
    input wire logic [15:0] drv,
    input wire logic [15:0] oe,
    input wire logic [15:0] ext,
    output logic     [15:0] pin
);
    timeunit 1ns;
    timeprecision 1ps;
    // undriven pins follow the outside level
    assign pin = (drv & oe) | (ext & ~oe);
endmodule

//--- expander_gpio_port_regs_bench.sv
module expander_gpio_port_regs_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_sys = 1'b0, rst_n = 1'b0, ld = 1'b0, we = 1'b0, re = 1'b0, rv;
    logic        ce = 1'b1;
    logic [7:0]  addr = 8'h00, wd = 8'h00, rdat, ptr;
    logic [15:0] pin, pout, poe, ext = 16'h1234, v;
    int          bad_count = 0, n_checks = 0;
    always #2.5 clk_sys = ~clk_sys;
    egp_port i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .ce(ce), .ptr_load(ld),
        .ptr_addr(addr), .wr_en(we), .wr_data(wd), .rd_en(re), .rd_data(rdat),
        .rd_valid(rv), .ptr(ptr), .pin_in(pin), .pin_out(pout), .pin_oe(poe));
    egp_pin_env i_env (.drv(pout), .oe(poe), .ext(ext), .pin(pin));
    task automatic chk(input string nm, input logic [15:0] e, g);
        n_checks++;
        if (g !== e)
        begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic op(input logic w, l, input logic [7:0] a, d);
        @(negedge clk_sys);
        {we, re, ld, addr, wd} = {w, !w, l, a, d};
    endtask
    task automatic idle();
        @(negedge clk_sys);
        {we, re, ld} = 3'h0;
    endtask
    task automatic wr48(input logic [7:0] a, input logic [47:0] b);
        for (int i = 0; i < 6; i++)
            op(1'b1, i == 0, a, b[8*i+:8]);
        idle();
    endtask
    task automatic rd16(input logic [7:0] a, output logic [15:0] q);
        for (int i = 0; i < 2; i++)
        begin
            op(1'b0, i == 0, a, 8'h00);
            idle();
            chk("rd_valid", 16'h0001, {15'h0000, rv});
            q[8*i+:8] = rdat;
        end
    endtask
    task automatic t_reset();
        chk("pin_oe", 16'h0000, poe);
        rd16(8'h16, v);
        chk("polarity", 16'h0000, v);
        $display("reset test done");
    endtask
    task automatic t_regs();
        // monitor bytes written first: must be dropped
        wr48(8'h10, 48'hf00f_c33c_ffff);
        chk("ptr", 16'h0016, {8'h00, ptr});
        idle();
        chk("pin_oe", 16'hf00f, poe);
        chk("pin_out", 16'hc00c, pout);
        rd16(8'h12, v);
        chk("output", 16'hc33c, v);
        $display("register test done");
    endtask
    task automatic t_mon();
        rd16(8'h10, v);
        chk("monitor", 16'hc23c, v);
        wr48(8'h16, 48'h0000_0000_aa55);
        rd16(8'h10, v);
        chk("inverted", 16'h6869, v);
        $display("monitor test done");
    endtask
    task automatic t_wrap();
        op(1'b1, 1'b1, 8'hff, 8'h77);
        idle();
        chk("ptr", 16'h0000, {8'h00, ptr});
        rd16(8'h18, v);
        chk("reserved", 16'h0000, v);
        rd16(8'h16, v);
        chk("polarity", 16'haa55, v);
        $display("wrap test done");
    endtask
    task automatic t_unused();
        // spare pins 11-4 parked as low outputs to save power
        wr48(8'h12, 48'h0000_ffff_c00c);
        idle();
        chk("pin_oe", 16'hffff, poe);
        chk("pin_out", 16'hc00c, pout);
        rd16(8'h10, v);
        chk("monitor", 16'hc00c, v);
        $display("unused pin test done");
    endtask
    task automatic t_freeze();
        @(negedge clk_sys);
        ce = 1'b0;
        // write and read attempts while frozen must leave no trace
        op(1'b1, 1'b1, 8'h12, 8'hff);
        op(1'b0, 1'b0, 8'h12, 8'h00);
        idle();
        chk("ptr", 16'h0012, {8'h00, ptr});
        chk("rd_valid", 16'h0000, {15'h0000, rv});
        chk("pin_out", 16'hc00c, pout);
        @(negedge clk_sys);
        ce = 1'b1;
        rd16(8'h12, v);
        chk("output", 16'hc00c, v);
        $display("clock enable test done");
    endtask
    task automatic t_rerun();
        @(negedge clk_sys);
        rst_n = 1'b0;
        @(negedge clk_sys);
        chk("pin_oe", 16'h0000, poe);
        chk("pin_out", 16'h0000, pout);
        @(negedge clk_sys);
        rst_n = 1'b1;
        rd16(8'h14, v);
        chk("direction", 16'h0000, v);
        rd16(8'h10, v);
        chk("monitor", 16'h1234, v);
        $display("mid-run reset test done");
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial
    begin
        repeat (20) @(negedge clk_sys);
        rst_n = 1'b1;
        t_reset();
        t_regs();
        t_mon();
        t_wrap();
        t_unused();
        t_freeze();
        t_rerun();
        results();
    end
endmodule
